// ==== src/fram_guard_pkg.sv ====
// constants, codes and types shared by the serial memory write-protect block
//
// Overview of operation
// - set-latch 06h, clear-latch 04h, status-read 05h, each as first byte of a frame.
// - status-write 01h, memory write 02h; any other opcode ignored until next select.
// - one opcode per select period, first byte, sampled MSB first on rising clock.
// - write-enable latch starts cleared, so no write is accepted before it is set.
// - set-latch opcode sets the latch, shown as status bit 1, 1 meaning writable.
// - status write data never loads the latch flag; a status-write frame clears it.
// - latch clears at select rising after clear-latch, status-write or memory-write frames.
// - clear-latch resets the latch so later writes are refused until set again.
// - status bit 7 pin guard, bits 3..2 block guard, bit 1 latch, fixed bits unwritable.
// - block guard bits and pin guard enable are retained, shipped default zero.
// - guard 00 none, 01 30000h-3FFFFh, 10 20000h-3FFFFh, 11 whole array.
// - pin guard enable 0 ignores protect pin; 1 with pin low blocks status writes.
// - protect pin guards only status; array writes depend on latch and block guard.
// - status-read returns exactly one byte with current status contents.
// - memory write is opcode, three address bytes using low 18 bits, then data.
// - address increments after each data byte, wrapping 3FFFFh to 00000h.
// - data shifted MSB first; select rising ends the write.
// - burst reaching a guarded address stops incrementing and drops later bytes.
// - each data byte is committed at its eighth bit, with no page buffer.
// - status bit 0 always reads 0, the device is never busy.
package fram_guard_pkg;

   // opcodes
   localparam logic [7:0] OP_SET_LATCH    = 8'h06;
   localparam logic [7:0] OP_CLEAR_LATCH  = 8'h04;
   localparam logic [7:0] OP_STATUS_READ  = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_MEM_WRITE    = 8'h02;

   // array geometry
   localparam int          ADDR_W      = 18;
   localparam int          DATA_W      = 8;
   localparam int          ADDR_BITS   = 24;
   localparam logic [17:0] GUARD_QUART = 18'h30000;
   localparam logic [17:0] GUARD_HALF  = 18'h20000;

   // status byte layout
   localparam int         ST_PIN_GUARD = 7;
   localparam int         ST_GUARD_HI  = 3;
   localparam int         ST_GUARD_LO  = 2;
   localparam int         ST_LATCH     = 1;
   localparam logic [7:0] ST_FIXED     = 8'h40;
   localparam logic [1:0] GUARD_RESET  = 2'h0;
   localparam logic       PGE_RESET    = 1'b0;

   // serial bit counts, last index of each phase
   localparam logic [4:0] BYTE_LAST = 5'h07;
   localparam logic [4:0] ADDR_LAST = 5'h17;

   // link state
   typedef enum logic [5:0]
   {
      LS_OPCODE   = 6'h01,
      LS_ADDR     = 6'h02,
      LS_DATA     = 6'h04,
      LS_STAT_IN  = 6'h08,
      LS_STAT_OUT = 6'h10,
      LS_IDLE     = 6'h20
   } link_state_type;

   // true when the block guard setting covers the address
   function automatic logic is_guarded(input logic [1:0] guard, input logic [17:0] addr);
      logic hit;
      hit = 1'b0;
      unique case (guard)
         2'h0:    hit = 1'b0;
         2'h1:    hit = (addr >= GUARD_QUART);
         2'h2:    hit = (addr >= GUARD_HALF);
         default: hit = 1'b1;
      endcase
      return hit;
   endfunction

endpackage

// ==== src/level_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module level_sync
#(
   parameter int         WIDTH    = 1,
   parameter logic [7:0] RST_BITS = 8'h00
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta <= RST_BITS[WIDTH-1:0];
         q    <= RST_BITS[WIDTH-1:0];
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule
`default_nettype wire

// ==== src/byte_array.sv ====
// byte memory, write port on the link clock, registered read port on the system clock
`timescale 1ns/1ps
`default_nettype none
module byte_array
(
   // write side
   input  wire logic                              wclk,
   input  wire logic                              we,
   input  wire logic [fram_guard_pkg::ADDR_W-1:0] waddr,
   input  wire logic [fram_guard_pkg::DATA_W-1:0] wdata,
   // read side
   input  wire logic                              rclk,
   input  wire logic                              rst,
   input  wire logic [fram_guard_pkg::ADDR_W-1:0] raddr,
   output logic      [fram_guard_pkg::DATA_W-1:0] rdata
);
   import fram_guard_pkg::*;

   logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

   // cells hold their value across resets, like the real array
   always_ff @(posedge wclk)
   begin
      if (we)
         cells[waddr] <= wdata;
   end

   // read data registered; a read of a cell written at the same moment is undefined
   always_ff @(posedge rclk or posedge rst)
   begin
      if (rst)
         rdata <= '0;
      else
         rdata <= cells[raddr];
   end

endmodule
`default_nettype wire

// ==== src/fram_guard.sv ====
// serial memory device: command decode, write latch, status register and guarded write path
`timescale 1ns/1ps
`default_nettype none
module fram_guard
(
   // system clock and reset
   input  wire logic                              clk,
   input  wire logic                              rst,
   // serial link, clocked by the master
   input  wire logic                              sck,
   input  wire logic                              cs_n,
   input  wire logic                              si,
   output logic                                   so,
   output logic                                   so_oe,
   // hardware protect pin, low blocks status writes when enabled
   input  wire logic                              write_protect_n,
   // system side view
   output logic      [7:0]                        write_protect_status,
   input  wire logic [fram_guard_pkg::ADDR_W-1:0] mem_rd_addr,
   output logic      [fram_guard_pkg::DATA_W-1:0] mem_rd_data
);
   import fram_guard_pkg::*;

   // ---------------------------------------------------------------
   // system clock domain: latch and retained guard bits
   // ---------------------------------------------------------------
   logic       write_latch_flag;
   logic       block_guard_lo;
   logic       block_guard_hi;
   logic       pin_guard_enable;
   logic       cs_n_s;
   logic       cs_n_d;
   logic       wp_n_s;
   logic       tag_s;
   logic       tag_seen;

   // link domain signals seen here
   logic       frame_tag;
   logic [7:0] opcode_held;
   logic [7:0] status_data;
   logic       status_got;

   level_sync #(.WIDTH(1), .RST_BITS(8'h01)) u_cs_sync
   (
      .clk (clk),
      .rst (rst),
      .d   (cs_n),
      .q   (cs_n_s)
   );

   level_sync #(.WIDTH(1), .RST_BITS(8'h01)) u_wp_sync
   (
      .clk (clk),
      .rst (rst),
      .d   (write_protect_n),
      .q   (wp_n_s)
   );

   level_sync #(.WIDTH(1), .RST_BITS(8'h00)) u_tag_sync
   (
      .clk (clk),
      .rst (rst),
      .d   (frame_tag),
      .q   (tag_s)
   );

   // a frame ends when synchronised select rises; opcode fields are stable by then
   wire frame_end    = cs_n_s & ~cs_n_d & (tag_s != tag_seen);
   wire do_set       = frame_end & (opcode_held == OP_SET_LATCH);
   wire is_clear     = opcode_held == OP_CLEAR_LATCH;
   wire is_stat_wr   = opcode_held == OP_STATUS_WRITE;
   wire is_mem_wr    = opcode_held == OP_MEM_WRITE;
   wire do_clear     = frame_end & (is_clear | is_stat_wr | is_mem_wr);
   wire pin_blocks   = pin_guard_enable & ~wp_n_s;
   wire status_load  = frame_end & is_stat_wr & status_got & write_latch_flag
                       & ~pin_blocks;

   // latch: cleared at reset so nothing is written until set
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         write_latch_flag <= 1'b0;
      else if (do_set)
         write_latch_flag <= 1'b1;
      else if (do_clear)
         write_latch_flag <= 1'b0;
   end

   // retained bits; reset here stands for a factory-fresh part
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         block_guard_lo   <= GUARD_RESET[0];
         block_guard_hi   <= GUARD_RESET[1];
         pin_guard_enable <= PGE_RESET;
      end
      else if (status_load)
      begin
         block_guard_lo   <= status_data[ST_GUARD_LO];
         block_guard_hi   <= status_data[ST_GUARD_HI];
         pin_guard_enable <= status_data[ST_PIN_GUARD];
      end
   end

   // edge history and frame bookkeeping
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cs_n_d   <= 1'b1;
         tag_seen <= 1'b0;
      end
      else
      begin
         cs_n_d <= cs_n_s;
         if (frame_end)
            tag_seen <= tag_s;
      end
   end

   // status image: fixed bits and a busy bit that never sets
   wire [7:0] status_now = ST_FIXED
                         | ({7'h00, pin_guard_enable} << ST_PIN_GUARD)
                         | ({7'h00, block_guard_hi} << ST_GUARD_HI)
                         | ({7'h00, block_guard_lo} << ST_GUARD_LO)
                         | ({7'h00, write_latch_flag} << ST_LATCH);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         write_protect_status <= ST_FIXED;
      else
         write_protect_status <= status_now;
   end

   // ---------------------------------------------------------------
   // link clock domain; select high holds the frame logic in reset
   // ---------------------------------------------------------------
   link_state_type      state;
   link_state_type      next_state;
   logic [4:0]          cnt;
   logic [23:0]         shift;
   logic [ADDR_W-1:0]   waddr;
   logic [7:0]          status_l;

   wire frame_rst = rst | cs_n;

   // status as seen on the link; it is resampled on each rising sck edge
   level_sync #(.WIDTH(8), .RST_BITS(ST_FIXED)) u_stat_sync
   (
      .clk (sck),
      .rst (rst),
      .d   (status_now),
      .q   (status_l)
   );

   wire        wel_l     = status_l[ST_LATCH];
   wire [1:0]  guard_l   = {status_l[ST_GUARD_HI], status_l[ST_GUARD_LO]};
   wire [7:0]  byte_in   = {shift[6:0], si};
   wire        byte_end  = cnt == BYTE_LAST;
   wire        addr_end  = cnt == ADDR_LAST;
   wire        op_end    = (state == LS_OPCODE) & byte_end;
   wire        data_end  = (state == LS_DATA) & byte_end;
   wire        addr_hit  = is_guarded(guard_l, waddr);
   wire        mem_we    = data_end & wel_l & ~addr_hit;
   wire [23:0] addr_in   = {shift[22:0], si};

   // next state of the command sequence
   always_comb
   begin
      next_state = state;
      unique case (state)
         LS_OPCODE:
         begin
            if (byte_end)
            begin
               if (byte_in == OP_MEM_WRITE)
                  next_state = LS_ADDR;
               else if (byte_in == OP_STATUS_WRITE)
                  next_state = LS_STAT_IN;
               else if (byte_in == OP_STATUS_READ)
                  next_state = LS_STAT_OUT;
               else
                  next_state = LS_IDLE;
            end
         end
         LS_ADDR:
         begin
            if (addr_end)
               next_state = LS_DATA;
         end
         LS_DATA:
         begin
            if (byte_end & addr_hit)
               next_state = LS_IDLE;
         end
         LS_STAT_IN:
         begin
            if (byte_end)
               next_state = LS_IDLE;
         end
         LS_STAT_OUT:
         begin
            if (byte_end)
               next_state = LS_IDLE;
         end
         LS_IDLE:
            next_state = LS_IDLE;
      endcase
   end

   // bit counter restarts at each phase change and each byte of the opcode, data and status phases; the idle state holds it
   wire       phase_end = (state == LS_ADDR) ? addr_end : byte_end;
   wire [4:0] next_cnt  = (state == LS_IDLE) ? cnt : (phase_end ? 5'h00 : 5'(cnt + 5'h01));

   // frame state, cleared whenever select is high
   always_ff @(posedge sck or posedge frame_rst)
   begin
      if (frame_rst)
      begin
         state <= LS_OPCODE;
         cnt   <= 5'h00;
         shift <= 24'h000000;
      end
      else
      begin
         state <= next_state;
         cnt   <= next_cnt;
         shift <= addr_in;
      end
   end

   // write address: low 18 bits of the address field, natural wrap
   always_ff @(posedge sck or posedge frame_rst)
   begin
      if (frame_rst)
         waddr <= '0;
      else if ((state == LS_ADDR) & addr_end)
         waddr <= addr_in[ADDR_W-1:0];
      else if (data_end & ~addr_hit)
         waddr <= ADDR_W'(waddr + 1'b1);
   end

   // results that must outlive the frame; the tag toggle tells the system side
   always_ff @(posedge sck or posedge rst)
   begin
      if (rst)
      begin
         frame_tag   <= 1'b0;
         opcode_held <= 8'h00;
         status_data <= 8'h00;
         status_got  <= 1'b0;
      end
      else if (op_end)
      begin
         frame_tag   <= ~frame_tag;
         opcode_held <= byte_in;
         status_got  <= 1'b0;
      end
      else if ((state == LS_STAT_IN) & byte_end)
      begin
         status_data <= byte_in;
         status_got  <= 1'b1;
      end
   end

   // status byte goes out on falling edges, most significant bit first
   always_ff @(negedge sck or posedge frame_rst)
   begin
      if (frame_rst)
      begin
         so    <= 1'b0;
         so_oe <= 1'b0;
      end
      else
      begin
         so_oe <= state == LS_STAT_OUT;
         so    <= status_l[~cnt[2:0]];
      end
   end

   // array: each byte lands at its eighth rising edge
   byte_array u_array
   (
      .wclk  (sck),
      .we    (mem_we),
      .waddr (waddr),
      .wdata (byte_in),
      .rclk  (clk),
      .rst   (rst),
      .raddr (mem_rd_addr),
      .rdata (mem_rd_data)
   );

endmodule
`default_nettype wire

// ==== dv/fram_guard_props.sv ====
// assertions watching the ports of the serial memory write-protect block
`timescale 1ns/1ps
`default_nettype none
module fram_guard_props
(
   // clocks and reset
   input wire logic                              clk,
   input wire logic                              rst,
   // serial link
   input wire logic                              sck,
   input wire logic                              cs_n,
   input wire logic                              si,
   input wire logic                              so,
   input wire logic                              so_oe,
   // protect pin and system view
   input wire logic                              write_protect_n,
   input wire logic [7:0]                        write_protect_status,
   input wire logic [fram_guard_pkg::ADDR_W-1:0] mem_rd_addr,
   input wire logic [fram_guard_pkg::DATA_W-1:0] mem_rd_data
);
   import fram_guard_pkg::*;

   logic [5:0] bit_cnt;
   logic [7:0] op_sh;

   // rising sck count in the frame; select high clears it at once, as it does the link logic
   always_ff @(posedge sck or posedge cs_n)
      if (cs_n)
         bit_cnt <= 6'h00;
      else if (bit_cnt != 6'h3f)
         bit_cnt <= bit_cnt + 6'h01;

   // opcode capture, no reset needed since only the first eight bits are looked at
   always_ff @(posedge sck)
      if (bit_cnt < 6'h08)
         op_sh <= {op_sh[6:0], si};

   property p_fixed_bits;
      @(posedge clk) disable iff (rst) write_protect_status[6:4] == 3'h4 && !write_protect_status[0];
   endproperty
   a_fixed_bits: assert property (p_fixed_bits) else $error("fixed status bits wrong");

   property p_oe_idle;
      @(posedge clk) disable iff (rst) cs_n && $past(cs_n) |-> !so_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("output enabled while deselected");

   property p_commit_at_end;
      @(posedge clk) disable iff (rst) !$stable(write_protect_status[7:1]) |-> $past(cs_n, 2);
   endproperty
   a_commit_at_end: assert property (p_commit_at_end) else $error("status changed inside a frame");

   property p_set_keeps_guard;
      @(posedge clk) disable iff (rst) $rose(write_protect_status[1]) |-> $stable(write_protect_status[7:2]);
   endproperty
   a_set_keeps_guard: assert property (p_set_keeps_guard) else $error("latch set moved guard bits");

   property p_write_clears_latch;
      @(posedge clk) disable iff (rst) !$stable(write_protect_status[7:2]) |-> !write_protect_status[1];
   endproperty
   a_write_clears_latch: assert property (p_write_clears_latch) else $error("latch left set");

   property p_pin_blocks;
      @(posedge clk) disable iff (rst)
         !$stable(write_protect_status[7:2]) |-> !$past(write_protect_status[7]) || $past(write_protect_n, 6);
   endproperty
   a_pin_blocks: assert property (p_pin_blocks) else $error("status written with pin low");

   property p_oe_only_read;
      @(posedge sck) disable iff (rst || cs_n) bit_cnt == 6'h08 |-> so_oe == (op_sh == OP_STATUS_READ);
   endproperty
   a_oe_only_read: assert property (p_oe_only_read) else $error("output enable wrong after opcode");

   property p_oe_window;
      @(posedge sck) disable iff (rst || cs_n) so_oe |-> bit_cnt >= 6'h08 && bit_cnt <= 6'h0f;
   endproperty
   a_oe_window: assert property (p_oe_window) else $error("more than one status byte");

   property p_busy_bit;
      @(posedge sck) disable iff (rst || cs_n) so_oe && bit_cnt == 6'h0f |-> !so;
   endproperty
   a_busy_bit: assert property (p_busy_bit) else $error("busy bit sent high");
endmodule

bind fram_guard fram_guard_props u_fram_guard_props (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
   .so(so), .so_oe(so_oe), .write_protect_n(write_protect_n), .write_protect_status(write_protect_status),
   .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data));
`default_nettype wire

// ==== dv/spi_master_model.sv ====
// serial bus master model driving the link in mode 0 or mode 3
`timescale 1ns/1ps
`default_nettype none
module spi_master_model
(
   // link to the device
   output logic     sck,
   output logic     cs_n,
   output logic     si,
   input wire logic so
);
   // clock level outside frames: low in mode 0, high in mode 3
   bit mode3;

   // idle: deselected, clock parked low as mode 0 wants
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end

   // one select period at 64 ns per bit; tail adds bits of a cut-short byte; second byte slot read from so
   task automatic frame(input logic [7:0] b[$], input int tail, output logic [7:0] rx);
      int n;
      n = b.size() * 8;
      rx = 8'h00;
      cs_n = 1'b0;
      #32;
      for (int i = 0; i < n + tail; i++)
      begin
         // falling edge first; in mode 0 the clock is already low for the first bit, so no edge is made there
         sck = 1'b0;
         si = (i < n) ? b[i / 8][7 - i % 8] : 1'b1;
         #32 sck = 1'b1;
         if (i >= 8 && i < 16)
            rx = {rx[6:0], so};
         #32;
      end
      // mode 0 parks the clock low before release, mode 3 leaves it high after the last rise
      if (!mode3)
         sck = 1'b0;
      #32 cs_n = 1'b1;
      // released line flips so nothing leans on a held value
      si = ~si;
      // long gap so the system side surely takes the frame end
      #600;
   endtask

   // change clock polarity between frames only, while select is high
   task automatic set_mode(input bit m3);
      mode3 = m3;
      sck = m3;
      #64;
   endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the serial memory write-protect block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import fram_guard_pkg::*;

   logic              clk;
   logic              rst;
   logic              sck;
   logic              cs_n;
   logic              si;
   logic              so;
   logic              so_oe;
   logic              write_protect_n;
   logic [7:0]        write_protect_status;
   logic [ADDR_W-1:0] mem_rd_addr;
   logic [DATA_W-1:0] mem_rd_data;
   logic [7:0]        rx;
   logic [17:0]       base;
   logic [1:0]        g;
   int                errors;
   int                n_tests;

   fram_guard u_fram_guard (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
      .write_protect_n(write_protect_n), .write_protect_status(write_protect_status),
      .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data));

   spi_master_model master (.sck(sck), .cs_n(cs_n), .si(si), .so(so));

   // 20 MHz system clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cmd(input logic [7:0] op);
      master.frame({op}, 0, rx);
   endtask

   // status seen both on the system view and over the link
   task automatic stat_chk(input logic [7:0] exp);
      @(negedge clk);
      check("status reg", write_protect_status, exp);
      master.frame({OP_STATUS_READ, 8'h00}, 0, rx);
      check("status read", rx, exp);
   endtask

   task automatic wr_mem(input logic [23:0] a, input logic [7:0] d[$], input int tail, input bit en);
      logic [7:0] q[$];
      if (en)
         cmd(OP_SET_LATCH);
      q = {OP_MEM_WRITE, a[23:16], a[15:8], a[7:0]};
      foreach (d[i])
         q.push_back(d[i]);
      master.frame(q, tail, rx);
   endtask

   task automatic wr_stat(input logic [7:0] v);
      cmd(OP_SET_LATCH);
      master.frame({OP_STATUS_WRITE, v}, 0, rx);
   endtask

   task automatic mem_chk(input logic [17:0] a, input logic [7:0] exp);
      @(posedge clk);
      mem_rd_addr <= a;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check("array byte", mem_rd_data, exp);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // cut a hang short
   initial
   begin
      #2000000;
      errors++;
      $display("ERROR run time expected done seen timeout");
      results();
   end

   // main sequence
   initial
   begin
      errors = 0;
      n_tests = 0;
      rst = 1'b1;
      write_protect_n = 1'b1;
      mem_rd_addr = '0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      stat_chk(8'h40);
      $display("test reset done");
      cmd(OP_SET_LATCH);
      stat_chk(8'h42);
      master.frame({8'h77, OP_CLEAR_LATCH}, 0, rx);
      stat_chk(8'h42);
      cmd(OP_CLEAR_LATCH);
      stat_chk(8'h40);
      master.frame({OP_STATUS_WRITE, 8'h0c}, 0, rx);
      stat_chk(8'h40);
      cmd(OP_SET_LATCH);
      master.frame({OP_STATUS_WRITE}, 5, rx);
      stat_chk(8'h40);
      $display("test latch done");
      wr_mem(24'h000010, {8'h11, 8'h22, 8'h33}, 0, 1);
      stat_chk(8'h40);
      mem_chk(18'h00010, 8'h11);
      mem_chk(18'h00012, 8'h33);
      wr_mem(24'h000010, {8'h99}, 0, 0);
      mem_chk(18'h00010, 8'h11);
      wr_mem(24'h000011, {8'h44}, 5, 1);
      mem_chk(18'h00011, 8'h44);
      mem_chk(18'h00012, 8'h33);
      wr_mem(24'hffffff, {8'h5a, 8'h6b}, 0, 1);
      mem_chk(18'h3ffff, 8'h5a);
      mem_chk(18'h00000, 8'h6b);
      $display("test memory write done");
      // guard settings 01 to 11: byte below the boundary, boundary, one above, after a known fill
      for (int i = 1; i < 4; i++)
      begin
         g = i[1:0];
         base = (g == 2'h1) ? GUARD_QUART : (g == 2'h2) ? GUARD_HALF : 18'h00000;
         wr_mem({6'h00, base - 18'h1}, {8'hc0, 8'hc0, 8'hc0}, 0, 1);
         wr_stat({4'h0, g, 2'h3});
         stat_chk({4'h4, g, 2'h0});
         wr_mem({6'h00, base - 18'h1}, {8'ha1, 8'ha2, 8'ha3}, 0, 1);
         mem_chk(base - 18'h1, (g == 2'h3) ? 8'hc0 : 8'ha1);
         mem_chk(base, 8'hc0);
         mem_chk(base + 18'h1, 8'hc0);
         wr_stat(8'h00);
      end
      $display("test block guard done");
      wr_stat(8'h82);
      stat_chk(8'hc0);
      @(posedge clk);
      write_protect_n <= 1'b0;
      wr_stat(8'h0c);
      stat_chk(8'hc0);
      wr_mem(24'h000020, {8'h77}, 0, 1);
      mem_chk(18'h00020, 8'h77);
      @(posedge clk);
      write_protect_n <= 1'b1;
      wr_stat(8'h00);
      stat_chk(8'h40);
      $display("test pin guard done");
      // reset in mid-run must drop the latch and bring retained bits to their shipped default
      wr_stat(8'h0c);
      cmd(OP_SET_LATCH);
      stat_chk(8'h4e);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check("status in reset", write_protect_status, 8'h40);
      @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      stat_chk(8'h40);
      $display("test second reset done");
      // clock idling high: first edge in a frame is a falling one
      master.set_mode(1'b1);
      wr_mem(24'h000030, {8'h3c, 8'h3d}, 0, 1);
      mem_chk(18'h00030, 8'h3c);
      mem_chk(18'h00031, 8'h3d);
      cmd(OP_SET_LATCH);
      stat_chk(8'h42);
      $display("test mode 3 done");
      results();
   end
endmodule
`default_nettype wire
